// [hw/xbc_regs.svh]
// field positions and timing counts of the external bus controller
`ifndef XBC_REGS_SVH
`define XBC_REGS_SVH

// --------------------------------------------------------------------------
// bus configuration word fields
// --------------------------------------------------------------------------
`define XBC_MCTC_HI 3
`define XBC_MCTC_LO 0
`define XBC_MTTC 4
`define XBC_RWDC 5
`define XBC_BT_HI 7
`define XBC_BT_LO 6
`define XBC_ALECTL 9
`define XBC_BUSACT 10

// --------------------------------------------------------------------------
// window select word fields
// --------------------------------------------------------------------------
`define XBC_WS_BASE_HI 15
`define XBC_WS_BASE_LO 4
`define XBC_WS_SIZE_HI 3
`define XBC_WS_SIZE_LO 0
`define XBC_WS_SIZE_MAX 4'ha

// --------------------------------------------------------------------------
// system configuration bits
// --------------------------------------------------------------------------
`define XBC_SC_AW_HI 1
`define XBC_SC_AW_LO 0
`define XBC_SC_SGL 2
`define XBC_SC_ROMEN 4
`define XBC_SC_ROMS1 5
`define XBC_SC_UNLATCHED_CHIPSEL_BIT 6

// --------------------------------------------------------------------------
// timing counts
// --------------------------------------------------------------------------
`define XBC_STRB_MIN 5'h03

`endif

// [hw/xbc_pkg.sv]
// types shared by the external bus controller files
package xbc_pkg;

  typedef enum logic [1:0] {
    XBC_BT_8DMX = 2'h0,
    XBC_BT_8MUX = 2'h1,
    XBC_BT_16DMX = 2'h2,
    XBC_BT_16MUX = 2'h3
  } xbc_btyp_t;

  typedef enum logic [1:0] {
    XBC_AW_22 = 2'h0,
    XBC_AW_20 = 2'h1,
    XBC_AW_18 = 2'h2,
    XBC_AW_16 = 2'h3
  } xbc_aw_t;

  typedef enum logic [2:0] {
    XBC_IDLE,
    XBC_ALE,
    XBC_DLY,
    XBC_STRB,
    XBC_TRI,
    XBC_DONE
  } xbc_state_t;

endpackage : xbc_pkg

// [hw/xbc_win_dec.sv]
// address window decoder: picks the bus configuration for an address
`timescale 1ns/10ps
`include "xbc_regs.svh"
module xbc_win_dec #(
  parameter int unsigned NWIN = 4
) (
  input wire logic [23:0] addr_i,
  input wire logic [NWIN-1:0][15:0] win_sel_i,
  input wire logic [NWIN:0][15:0] bus_cfg_i,
  output logic [2:0] win_o
);

  // ------------------------------------------------------------------------
  // window match
  // ------------------------------------------------------------------------
  function automatic logic hit(input logic [23:0] a, input logic [15:0] ws,
                               input logic en);
    logic [3:0] sz;
    logic [11:0] msk;
    sz = ws[`XBC_WS_SIZE_HI:`XBC_WS_SIZE_LO];
    // larger codes would exceed the largest contiguous window
    if (sz > `XBC_WS_SIZE_MAX) sz = `XBC_WS_SIZE_MAX;
    msk = 12'hfff << sz;
    hit = en && ((a[23:12] & msk) == (ws[`XBC_WS_BASE_HI:`XBC_WS_BASE_LO] & msk));
  endfunction : hit

  // ------------------------------------------------------------------------
  // priority: a higher window number overrides a lower one
  // ------------------------------------------------------------------------
  always_comb begin
    win_o = 3'h0;
    for (int i = 0; i < NWIN; i++) begin
      if (hit(addr_i, win_sel_i[i], bus_cfg_i[i+1][`XBC_BUSACT])) begin
        win_o = 3'(i + 1);
      end
    end
  end

endmodule : xbc_win_dec

// [hw/xbc_ctrl.sv]
// external bus controller: cycle sequencer, pin drivers and chip selects
//
// Behaviour
// - single-chip mode or 8/16-bit data, multiplexed or not, 16-22 bit address.
// - demultiplexed: address on address port, data on full or low data byte.
// - multiplexed: data port carries address first, then the data.
// - cycle time, tri-state time, latch strobe length, strobe delay programmable.
// - four windows, each a select word paired with a bus configuration.
// - overlapping windows: four beats three, two beats one.
// - addresses outside all windows use the default bus configuration.
// - four active-low chip selects: three windows and the default region.
// - unlatched chip-select bit six bypasses filtering; selects follow the address.
// - restricted space drives four, two or no upper address lines.
// - full address width drives all six upper address lines.
// - one window spans at most 4 Mbytes; windows reach 16 Mbytes total.
// - every location is reachable by byte or by word accesses.
// - mapped on-chip program memory segment is served without bus cycles.
// - address port carries the address also after switching to multiplexed.
`timescale 1ns/10ps
`include "xbc_regs.svh"
module xbc_ctrl #(
  parameter int unsigned NWIN = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic byte_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] sys_cfg_i,
  input wire logic [NWIN-1:0][15:0] win_sel_i,
  input wire logic [NWIN:0][15:0] bus_cfg_i,
  input wire logic [15:0] data_port_i,
  output logic busy_o,
  output logic done_o,
  output logic int_o,
  output logic err_o,
  output logic [15:0] rdata_o,
  output logic [15:0] data_port_o,
  output logic [15:0] data_port_oe_o,
  output logic [15:0] address_port_o,
  output logic [5:0] upper_addr_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic bhe_n_o,
  output logic [3:0] cs_n_o
);

  // ------------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------------
  function automatic logic [5:0] aw_mask(input logic [1:0] aw);
    case (xbc_pkg::xbc_aw_t'(aw))
      xbc_pkg::XBC_AW_20: aw_mask = 6'h0f;
      xbc_pkg::XBC_AW_18: aw_mask = 6'h03;
      xbc_pkg::XBC_AW_16: aw_mask = 6'h00;
      default: aw_mask = 6'h3f;
    endcase
  endfunction : aw_mask

  // window four has no select line of its own
  function automatic logic [3:0] cs_vec(input logic [2:0] w);
    cs_vec = (w < 3'h4) ? (4'h1 << w) : 4'h0;
  endfunction : cs_vec

  xbc_pkg::xbc_state_t st_q;
  logic [23:0] addr_q;
  logic [15:0] wdat_q;
  logic [15:0] cfg_q;
  logic [15:0] rdat_q;
  logic [15:0] d_s1_q;
  logic [15:0] d_s2_q;
  logic [2:0] win_q;
  logic [4:0] cnt_q;
  logic wr_q;
  logic byte_q;
  logic half_q;
  logic cap_q;
  logic cap_hi_q;
  logic [2:0] win_now;
  logic [23:0] dec_addr;
  logic rom_hit;
  logic sgl;
  logic bus16;
  logic mux;
  logic more;
  logic act;
  logic [4:0] strb_cnt;
  logic [4:0] ale_cnt;

  // ------------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------------
  assign dec_addr = (st_q == xbc_pkg::XBC_IDLE) ? addr_i : addr_q;
  assign sgl = sys_cfg_i[`XBC_SC_SGL];
  assign rom_hit = sys_cfg_i[`XBC_SC_ROMEN] && (addr_i[23:17] == 7'h00) &&
                   (addr_i[16] == sys_cfg_i[`XBC_SC_ROMS1]);
  assign bus16 = cfg_q[`XBC_BT_HI];
  assign mux = cfg_q[`XBC_BT_LO];
  // a word on an 8-bit bus is split into two byte cycles
  assign more = !bus16 && !byte_q && !half_q;
  assign act = (st_q != xbc_pkg::XBC_IDLE) && (st_q != xbc_pkg::XBC_DONE);
  // three strobe cycles at least: read data passes the pin synchroniser
  assign strb_cnt = 5'(cfg_q[`XBC_MCTC_HI:`XBC_MCTC_LO]) + `XBC_STRB_MIN - 5'h01;
  assign ale_cnt = cfg_q[`XBC_ALECTL] ? 5'h01 : 5'h00;

  xbc_win_dec #(
    .NWIN(NWIN)
  ) u_dec (
    .addr_i(dec_addr),
    .win_sel_i(win_sel_i),
    .bus_cfg_i(bus_cfg_i),
    .win_o(win_now)
  );

  // ------------------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= xbc_pkg::XBC_IDLE;
      addr_q <= 24'h000000;
      wdat_q <= 16'h0000;
      cfg_q <= 16'h0000;
      win_q <= 3'h0;
      cnt_q <= 5'h00;
      wr_q <= 1'b0;
      byte_q <= 1'b0;
      half_q <= 1'b0;
      int_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      case (st_q)
        xbc_pkg::XBC_IDLE: begin
          if (req_i) begin
            addr_q <= byte_i ? addr_i : {addr_i[23:1], 1'b0};
            wdat_q <= wdata_i;
            wr_q <= wr_i;
            byte_q <= byte_i;
            half_q <= 1'b0;
            win_q <= win_now;
            cfg_q <= bus_cfg_i[win_now];
            int_o <= rom_hit;
            err_o <= sgl && !rom_hit;
            if (rom_hit || sgl) begin
              st_q <= xbc_pkg::XBC_DONE;
            end else begin
              st_q <= xbc_pkg::XBC_ALE;
              cnt_q <= bus_cfg_i[win_now][`XBC_ALECTL] ? 5'h01 : 5'h00;
            end
          end
        end
        xbc_pkg::XBC_ALE: begin
          if (cnt_q == 5'h00) begin
            if (cfg_q[`XBC_RWDC]) begin
              st_q <= xbc_pkg::XBC_DLY;
            end else begin
              st_q <= xbc_pkg::XBC_STRB;
              cnt_q <= strb_cnt;
            end
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        xbc_pkg::XBC_DLY: begin
          st_q <= xbc_pkg::XBC_STRB;
          cnt_q <= strb_cnt;
        end
        xbc_pkg::XBC_STRB: begin
          if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
          end else if (!wr_q && cfg_q[`XBC_MTTC]) begin
            st_q <= xbc_pkg::XBC_TRI;
          end else if (more) begin
            half_q <= 1'b1;
            addr_q <= addr_q + 24'h000001;
            st_q <= xbc_pkg::XBC_ALE;
            cnt_q <= ale_cnt;
          end else begin
            st_q <= xbc_pkg::XBC_DONE;
          end
        end
        xbc_pkg::XBC_TRI: begin
          if (more) begin
            half_q <= 1'b1;
            addr_q <= addr_q + 24'h000001;
            st_q <= xbc_pkg::XBC_ALE;
            cnt_q <= ale_cnt;
          end else begin
            st_q <= xbc_pkg::XBC_DONE;
          end
        end
        xbc_pkg::XBC_DONE: begin
          st_q <= xbc_pkg::XBC_IDLE;
        end
        default: begin
          st_q <= xbc_pkg::XBC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= (st_q == xbc_pkg::XBC_DONE);
      busy_o <= (st_q == xbc_pkg::XBC_IDLE) ? req_i : (st_q != xbc_pkg::XBC_DONE);
    end
  end

  // ------------------------------------------------------------------------
  // read data capture
  // ------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      d_s1_q <= 16'h0000;
      d_s2_q <= 16'h0000;
    end else begin
      d_s1_q <= data_port_i;
      d_s2_q <= d_s1_q;
    end
  end

  // sampled one cycle after the strobe state ends: the memory must hold
  // data valid over the last three strobe cycles
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cap_q <= 1'b0;
      cap_hi_q <= 1'b0;
      rdat_q <= 16'h0000;
    end else begin
      cap_q <= (st_q == xbc_pkg::XBC_STRB) && (cnt_q == 5'h00) && !wr_q;
      cap_hi_q <= half_q;
      if (cap_q) begin
        if (bus16) begin
          if (!byte_q) begin
            rdat_q <= d_s2_q;
          end else begin
            rdat_q <= {8'h00, addr_q[0] ? d_s2_q[15:8] : d_s2_q[7:0]};
          end
        end else if (byte_q) begin
          rdat_q <= {8'h00, d_s2_q[7:0]};
        end else if (cap_hi_q) begin
          rdat_q[15:8] <= d_s2_q[7:0];
        end else begin
          rdat_q[7:0] <= d_s2_q[7:0];
        end
      end
    end
  end
  assign rdata_o = rdat_q;

  // ------------------------------------------------------------------------
  // pin drivers, one cycle behind the sequencer
  // ------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ale_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      bhe_n_o <= 1'b1;
      address_port_o <= 16'h0000;
      upper_addr_o <= 6'h00;
      data_port_o <= 16'h0000;
      data_port_oe_o <= 16'h0000;
    end else begin
      ale_o <= (st_q == xbc_pkg::XBC_ALE);
      rd_n_o <= !((st_q == xbc_pkg::XBC_STRB) && !wr_q);
      wr_n_o <= !((st_q == xbc_pkg::XBC_STRB) && wr_q);
      bhe_n_o <= !(act && bus16 && (!byte_q || addr_q[0]));
      // kept driven in every mode so a later mux switch keeps the address
      address_port_o <= addr_q[15:0];
      upper_addr_o <= addr_q[21:16] & aw_mask(sys_cfg_i[`XBC_SC_AW_HI:`XBC_SC_AW_LO]);
      if ((st_q == xbc_pkg::XBC_ALE) && mux) begin
        data_port_o <= addr_q[15:0];
        data_port_oe_o <= 16'hffff;
      end else if (wr_q && ((st_q == xbc_pkg::XBC_DLY) || (st_q == xbc_pkg::XBC_STRB))) begin
        if (bus16) begin
          data_port_o <= byte_q ? {wdat_q[7:0], wdat_q[7:0]} : wdat_q;
          data_port_oe_o <= 16'hffff;
        end else begin
          data_port_o <= {8'h00, half_q ? wdat_q[15:8] : wdat_q[7:0]};
          data_port_oe_o <= 16'h00ff;
        end
      end else begin
        data_port_oe_o <= 16'h0000;
      end
    end
  end

  // ------------------------------------------------------------------------
  // chip selects
  // ------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cs_n_o <= 4'hf;
    end else if (sgl) begin
      cs_n_o <= 4'hf;
    end else if (sys_cfg_i[`XBC_SC_UNLATCHED_CHIPSEL_BIT]) begin
      // unfiltered: follows the address, stays on the last one between cycles
      cs_n_o <= ~cs_vec((st_q == xbc_pkg::XBC_IDLE) ? win_q : win_now);
    end else begin
      cs_n_o <= act ? ~cs_vec(win_q) : 4'hf;
    end
  end

  // ------------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_take_ext;
    st_q == xbc_pkg::XBC_IDLE && req_i && !rom_hit && !sgl;
  endsequence
  sequence s_take_int;
    st_q == xbc_pkg::XBC_IDLE && req_i && (rom_hit || sgl);
  endsequence
  sequence s_quiet_done;
    st_q == xbc_pkg::XBC_DONE ##1 (done_o && rd_n_o && wr_n_o && !ale_o);
  endsequence

  a_internal_no_cycle: assert property (s_take_int |=> s_quiet_done)
    else $error("internal access produced a bus cycle");
  a_default_cfg: assert property (s_take_ext ##0 win_now == 3'h0 |=>
    cfg_q == $past(bus_cfg_i[0]))
    else $error("default configuration not used");
  a_window_cfg: assert property (s_take_ext |=> win_q == $past(win_now) &&
    st_q == xbc_pkg::XBC_ALE)
    else $error("window not latched at start of cycle");
  a_strobe_len: assert property ($fell(rd_n_o) |-> (!rd_n_o)[*3])
    else $error("read strobe shorter than three cycles");
  a_mux_address: assert property (ale_o && mux |->
    data_port_oe_o == 16'hffff && data_port_o == address_port_o)
    else $error("multiplexed address phase wrong");
  a_low_lane: assert property (!wr_n_o && !bus16 |-> data_port_oe_o == 16'h00ff)
    else $error("8-bit bus drives the high byte");
  a_address_port: assert property (##1 address_port_o == $past(addr_q[15:0]))
    else $error("address port does not follow the address");
  a_upper_mask: assert property ((upper_addr_o &
    ~aw_mask($past(sys_cfg_i[`XBC_SC_AW_HI:`XBC_SC_AW_LO]))) == 6'h00)
    else $error("restricted upper address line driven");
  a_full_width: assert property ($past(sys_cfg_i[`XBC_SC_AW_HI:`XBC_SC_AW_LO]) == 2'h0 |->
    upper_addr_o == $past(addr_q[21:16]))
    else $error("upper address lines incomplete");
  a_cs_onehot: assert property ($onehot0(~cs_n_o))
    else $error("more than one chip select active");
  a_cs_unlatched: assert property (sys_cfg_i[`XBC_SC_UNLATCHED_CHIPSEL_BIT] && !sgl &&
    st_q != xbc_pkg::XBC_IDLE |=>
    cs_n_o == ~cs_vec($past(win_now)))
    else $error("unlatched chip select not from address");
  a_single_chip: assert property (sgl |=> cs_n_o == 4'hf ##1 rd_n_o && wr_n_o)
    else $error("single-chip mode shows bus activity");

endmodule : xbc_ctrl

// [sim/xbc_mem_model.sv]
// asynchronous memory model on the far side of the bus controller
`timescale 1ns/10ps
module xbc_mem_model (
  input wire logic clk_sys_i,
  input wire logic wide8_i,
  input wire logic mux_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic bhe_n_i,
  input wire logic [15:0] dp_i,
  input wire logic [15:0] address_port_i,
  output logic [15:0] dp_o
);
  logic [7:0] mem [256];
  logic [15:0] a_q;
  logic [15:0] last_q;
  logic [7:0] ia;
  logic [7:0] lo;
  logic [7:0] hi;

  initial begin
    a_q = 16'h0000;
    last_q = 16'h0000;
    foreach (mem[i]) mem[i] = 8'h00;
  end

  // --------------------------------
  // lanes and release behaviour
  // --------------------------------
  assign ia = wide8_i ? a_q[7:0] : {a_q[7:1], 1'b0};
  assign lo = mem[ia];
  assign hi = wide8_i ? lo : mem[ia | 8'h01];
  // no pull-up here, so a released bus shows the inverse of its last value
  assign dp_o = rd_n_i ? ~last_q : {hi, lo};

  always @(posedge clk_sys_i) begin
    if (ale_i) begin
      a_q <= mux_i ? dp_i : address_port_i;
    end
    if (!rd_n_i) begin
      last_q <= {hi, lo};
    end
    if (!wr_n_i && (wide8_i || !a_q[0])) begin
      mem[ia] <= dp_i[7:0];
    end
    if (!wr_n_i && !wide8_i && !bhe_n_i) begin
      mem[ia | 8'h01] <= dp_i[15:8];
    end
  end
endmodule : xbc_mem_model

// [sim/tb.sv]
// self-checking bench for the external bus controller
`timescale 1ns/10ps
`include "xbc_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb;
  logic clk_sys_i;
  logic rst_i;
  logic req, wr, byt, busy, done, intl, err, ale, rd_n, wr_n, bhe_n;
  logic [23:0] addr;
  logic [15:0] wdata, sys_cfg, dp_wire, mem_drv, rdata, dp_out, dp_oe, aport;
  logic [3:0][15:0] win_sel;
  logic [4:0][15:0] bus_cfg;
  logic [5:0] upper;
  logic [3:0] cs_n, cs_and;
  logic saw_rd, saw_wr, saw_ale, bhe_and;
  int fails = 0;
  int cmp_count = 0;
  int lat;

  // the pins carry the controller's value where it drives, else the memory's
  assign dp_wire = (dp_oe & dp_out) | (~dp_oe & mem_drv);

  xbc_ctrl xbc_ctrl_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req), .wr_i(wr),
    .byte_i(byt), .addr_i(addr), .wdata_i(wdata), .sys_cfg_i(sys_cfg), .win_sel_i(win_sel),
    .bus_cfg_i(bus_cfg), .data_port_i(dp_wire), .busy_o(busy), .done_o(done), .int_o(intl),
    .err_o(err), .rdata_o(rdata), .data_port_o(dp_out), .data_port_oe_o(dp_oe),
    .address_port_o(aport), .upper_addr_o(upper), .ale_o(ale), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .bhe_n_o(bhe_n), .cs_n_o(cs_n));

  xbc_mem_model xbc_mem_model_inst (.clk_sys_i(clk_sys_i), .wide8_i(!bus_cfg[0][7]),
    .mux_i(bus_cfg[0][6]), .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n), .bhe_n_i(bhe_n),
    .dp_i(dp_wire), .address_port_i(aport), .dp_o(mem_drv));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // --------------------------------
  // helpers
  // --------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // edges from take to done for a 16-bit bus cycle
  function automatic int exp_lat(input logic [15:0] c, input logic w);
    return 6 + int'(c[`XBC_ALECTL]) + int'(c[`XBC_RWDC]) + int'(c[`XBC_MCTC_HI:`XBC_MCTC_LO])
      + int'(!w && c[`XBC_MTTC]);
  endfunction : exp_lat

  // one access; the leading edge lets done fall before the next request
  task automatic acc(input logic w, input logic b, input logic [23:0] a,
                     input logic [15:0] d);
    @(negedge clk_sys_i);
    req = 1'b1;
    wr = w;
    byt = b;
    addr = a;
    wdata = d;
    cs_and = 4'hf;
    saw_rd = 1'b0;
    saw_wr = 1'b0;
    saw_ale = 1'b0;
    bhe_and = 1'b1;
    lat = -1;
    for (int n = 0; n < 200 && lat < 0; n++) begin
      @(negedge clk_sys_i);
      req = 1'b0;
      cs_and &= cs_n;
      saw_rd |= !rd_n;
      saw_wr |= !wr_n;
      saw_ale |= ale;
      bhe_and &= bhe_n;
      // the take edge counts as one: n starts after it
      if (done === 1'b1) begin
        lat = n + 1;
      end
    end
    if (lat < 0) begin
      `CHK("done_wait", 1'b1, done)
      give_verdict();
    end
  endtask : acc

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset();
    `CHK("cs_rst", 4'hf, cs_n)
    `CHK("pins_rst", 21'h0e0000, {ale, rd_n, wr_n, bhe_n, busy, dp_oe})
  endtask : t_reset

  task automatic t_modes();
    logic [15:0] cfgs [4] = '{16'h0080, 16'h02f5, 16'h0000, 16'h0272};
    for (int i = 0; i < 4; i++) begin
      bus_cfg[0] = cfgs[i];
      acc(1'b1, 1'b0, 24'h000100 + 24'(i * 4), 16'h1357 + 16'(i));
      if (cfgs[i][7]) `CHK("wr_lat", exp_lat(cfgs[i], 1'b1), lat)
      acc(1'b0, 1'b0, 24'h000100 + 24'(i * 4), 16'h0000);
      `CHK("rdata", 16'h1357 + 16'(i), rdata)
      `CHK("cs_idle", 4'hf, cs_n)
      if (cfgs[i][7]) `CHK("rd_lat", exp_lat(cfgs[i], 1'b0), lat)
      if (cfgs[i][7]) `CHK("aport", 16'h0100 + 16'(i * 4), aport)
    end
    bus_cfg[0] = 16'h0080;
  endtask : t_modes

  task automatic t_bytes();
    acc(1'b1, 1'b1, 24'h000013, 16'h005a);
    `CHK("bhe_odd", 1'b0, bhe_and)
    acc(1'b1, 1'b1, 24'h000012, 16'h00c3);
    `CHK("bhe_even", 1'b1, bhe_and)
    acc(1'b0, 1'b0, 24'h000012, 16'h0000);
    `CHK("word", 16'h5ac3, rdata)
    acc(1'b0, 1'b1, 24'h000013, 16'h0000);
    `CHK("byte", 16'h005a, rdata)
  endtask : t_bytes

  task automatic t_windows();
    logic [23:0] ad [6] = '{24'h001000, 24'h001000, 24'h000800, 24'h400000,
                            24'h7ff000, 24'h800000};
    logic [3:0] cs [6] = '{4'hd, 4'hb, 4'hb, 4'hf, 4'h7, 4'he};
    int ex [6] = '{1, 2, 2, 4, 3, 0};
    // window 3 asks for more than 4 Mbytes and must be clamped
    win_sel = {16'h4000, 16'h400f, 16'h0001, 16'h0010};
    bus_cfg = {16'h0484, 16'h0483, 16'h0482, 16'h0481, 16'h0080};
    for (int i = 0; i < 6; i++) begin
      bus_cfg[2][`XBC_BUSACT] = (i != 0);
      acc(1'b0, 1'b0, ad[i], 16'h0000);
      `CHK("win_cs", cs[i], cs_and)
      `CHK("win_lat", 6 + ex[i], lat)
    end
  endtask : t_windows

  task automatic t_upper();
    for (int i = 0; i < 4; i++) begin
      sys_cfg = 16'(i);
      acc(1'b0, 1'b0, 24'h3f0000, 16'h0000);
      `CHK("upper", 6'h3f >> (2 * i), upper)
    end
    sys_cfg = 16'h0000;
  endtask : t_upper

  task automatic t_single();
    sys_cfg = 16'h0004;
    acc(1'b1, 1'b0, 24'h000200, 16'h0000);
    `CHK("err", 1'b1, err)
    `CHK("quiet", 7'h7f, {cs_and, !saw_rd, !saw_wr, !saw_ale})
    `CHK("sc_lat", 2, lat)
    sys_cfg = 16'h0000;
  endtask : t_single

  task automatic t_progmem();
    logic [15:0] sc [3] = '{16'h0010, 16'h0030, 16'h0030};
    logic [23:0] ad [3] = '{24'h001234, 24'h011234, 24'h001234};
    logic ie [3] = '{1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      sys_cfg = sc[i];
      acc(1'b0, 1'b0, ad[i], 16'h0000);
      `CHK("int", ie[i], intl)
      if (ie[i]) `CHK("pm_quiet", 6'h3f, {cs_and, !saw_rd, !saw_ale})
    end
    sys_cfg = 16'h0000;
  endtask : t_progmem

  task automatic t_unlatched();
    sys_cfg = 16'h0040;
    acc(1'b0, 1'b0, 24'h001000, 16'h0000);
    @(negedge clk_sys_i);
    `CHK("cs_hold", 4'hb, cs_n)
    sys_cfg = 16'h0000;
  endtask : t_unlatched

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    rst_i = 1'b1;
    req = 1'b0;
    wr = 1'b0;
    byt = 1'b0;
    addr = 24'h000000;
    wdata = 16'h0000;
    sys_cfg = 16'h0000;
    win_sel = '0;
    bus_cfg = {64'h0, 16'h0080};
    repeat (20) @(negedge clk_sys_i);
    t_reset();
    rst_i = 1'b0;
    t_modes();
    t_bytes();
    t_windows();
    t_upper();
    t_single();
    t_progmem();
    t_unlatched();
    give_verdict();
  end
endmodule : tb
